// ---- hdl/dsc_serial_ctrl.sv ----
`timescale 1ns/1ns
`default_nettype none

module dsc_serial_ctrl
  import dsc_pkg::*;
(
  // System clock and controls
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       clkEn,
  // Device pins
  input  wire logic       hwResetN,
  input  wire logic       busModeI2c,
  input  wire logic       devAddrBit1,
  input  wire logic       devAddrBit0,
  // Three-wire port
  input  wire logic       ctrlSerialClock,
  input  wire logic       portSelectN,
  input  wire logic       ctrlSerialIn,
  // Two-wire port
  input  wire logic       i2cClockIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaDriveN,
  // Zero detection
  input  wire logic [5:0] chanZero,
  output logic            zeroFlagOutA,
  output logic            zeroFlagOutB,
  // Decoded controls
  output dsc_ctrl_t       ctrlOut
);

  typedef enum logic [2:0] {
    BUS_IDLE,
    BUS_DEV,
    BUS_DEV_ACK,
    BUS_REG,
    BUS_REG_ACK,
    BUS_DATA,
    BUS_DATA_ACK,
    BUS_SKIP
  } dsc_bus_t;

  logic [SYNC_W-1:0]     pinRaw;
  logic [SYNC_W-1:0]     pinMeta;
  logic [SYNC_W-1:0]     pinSync;
  logic                  csnLast;
  logic                  sclLast;
  logic                  sdaLast;
  logic                  regReset;
  logic                  modeI2c;
  logic [FRAME_BITS-1:0] wireFrame;
  logic [FRAME_BITS-1:0] frameHeld;
  logic                  csnRise;
  logic                  wireMatch;
  logic                  wireValid;
  logic                  sclRise;
  logic                  sclFall;
  logic                  busStart;
  logic                  busStop;
  dsc_bus_t              busState;
  logic [3:0]            bitCnt;
  logic [7:0]            byteReg;
  logic [4:0]            addrCnt;
  logic                  devMatch;
  logic                  busValid;
  logic                  wrValid;
  dsc_write_t            wrItem;
  logic [7:0]            regFile [REG_COUNT];

  // The straps, reset, select and two-wire pins pass two flip-flops; the three-wire shifter and chanZero take their pins raw.
  assign pinRaw = {devAddrBit0, devAddrBit1, sdaIn, i2cClockIn,
                   busModeI2c, portSelectN, hwResetN};

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pinMeta <= SYNC_IDLE;
      pinSync <= SYNC_IDLE;
    end else if (clkEn) begin
      pinMeta <= pinRaw;
      pinSync <= pinMeta;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      csnLast <= 1'b1;
      sclLast <= 1'b1;
      sdaLast <= 1'b1;
    end else if (clkEn) begin
      csnLast <= pinSync[SYNC_CSN];
      sclLast <= pinSync[SYNC_SCL];
      sdaLast <= pinSync[SYNC_SDA];
    end
  end

  assign modeI2c  = pinSync[SYNC_MODE];
  assign regReset = reset | ~pinSync[SYNC_HWR];

  // Three-wire link: shifting runs on the link clock.
  dsc_wire_shift u_wire_shift (
    .ctrlSerialClock (ctrlSerialClock),
    .portSelectN     (portSelectN),
    .ctrlSerialIn    (ctrlSerialIn),
    .frameBits       (wireFrame)
  );

  // The link clock is idle while select is high, so the word is taken
  // here only after the synchronised select has risen.
  assign csnRise = pinSync[SYNC_CSN] & ~csnLast & ~modeI2c;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      frameHeld <= '0;
    end else if (clkEn && csnRise) begin
      frameHeld <= wireFrame;
    end
  end

  assign wireMatch =
    (wireFrame[FRAME_CHIP_HI] == pinSync[SYNC_DEV_ADDR_BIT1]) &&
    (wireFrame[FRAME_CHIP_LO] == CHIP_LOW_FIXED) &&
    (wireFrame[FRAME_RW] == WIRE_WRITE);

  assign wireValid = csnRise & wireMatch;

  // Two-wire link, oversampled on the system clock.
  assign sclRise  = pinSync[SYNC_SCL] & ~sclLast;
  assign sclFall  = ~pinSync[SYNC_SCL] & sclLast;
  assign busStart = pinSync[SYNC_SCL] & sclLast & sdaLast & ~pinSync[SYNC_SDA];
  assign busStop  = pinSync[SYNC_SCL] & sclLast & ~sdaLast & pinSync[SYNC_SDA];

  assign devMatch =
    (byteReg[7:3] == BUS_ADDR_FIXED) &&
    (byteReg[2] == pinSync[SYNC_DEV_ADDR_BIT1]) &&
    (byteReg[1] == pinSync[SYNC_DEV_ADDR_BIT0]);

  always_ff @(posedge ref_clk) begin
    if (reset || !modeI2c) begin
      busState <= BUS_IDLE;
    end else if (clkEn) begin
      if (busStop) begin
        busState <= BUS_IDLE;
      end else if (busStart) begin
        busState <= BUS_DEV;
      end else if (sclFall) begin
        unique case (busState)
          BUS_IDLE: begin
            busState <= BUS_IDLE;
          end
          BUS_DEV: begin
            if (bitCnt == BYTE_BITS) begin
              if (devMatch && !byteReg[0]) begin
                busState <= BUS_DEV_ACK;
              end else begin
                busState <= BUS_SKIP;
              end
            end
          end
          BUS_DEV_ACK: begin
            busState <= BUS_REG;
          end
          BUS_REG: begin
            if (bitCnt == BYTE_BITS) begin
              busState <= BUS_REG_ACK;
            end
          end
          BUS_REG_ACK: begin
            busState <= BUS_DATA;
          end
          BUS_DATA: begin
            if (bitCnt == BYTE_BITS) begin
              busState <= BUS_DATA_ACK;
            end
          end
          BUS_DATA_ACK: begin
            busState <= BUS_DATA;
          end
          BUS_SKIP: begin
            busState <= BUS_SKIP;
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bitCnt <= '0;
    end else if (clkEn) begin
      if (busStart || (sclFall && bitCnt == BYTE_BITS)) begin
        bitCnt <= '0;
      end else if (sclRise && (busState == BUS_DEV || busState == BUS_REG ||
                               busState == BUS_DATA)) begin
        bitCnt <= bitCnt + 4'd1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      byteReg <= '0;
    end else if (clkEn && sclRise) begin
      byteReg <= {byteReg[6:0], pinSync[SYNC_SDA]};
    end
  end

  // Acknowledge is driven from the fall after bit eight to the next fall.
  always_ff @(posedge ref_clk) begin
    if (reset || !modeI2c) begin
      sdaDriveN <= 1'b1;
    end else if (clkEn) begin
      if (busStop || busStart) begin
        sdaDriveN <= 1'b1;
      end else if (sclFall) begin
        if (bitCnt == BYTE_BITS) begin
          unique case (busState)
            BUS_DEV:  sdaDriveN <= ~(devMatch & ~byteReg[0]);
            BUS_REG:  sdaDriveN <= 1'b0;
            BUS_DATA: sdaDriveN <= 1'b0;
            default:  sdaDriveN <= 1'b1;
          endcase
        end else begin
          sdaDriveN <= 1'b1;
        end
      end
    end
  end

  assign sdaOut = 1'b0;

  assign busValid = clkEn & sclFall & (bitCnt == BYTE_BITS) & (busState == BUS_DATA);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      addrCnt <= '0;
    end else if (clkEn && sclFall && bitCnt == BYTE_BITS) begin
      if (busState == BUS_REG) begin
        addrCnt <= byteReg[4:0];
      end else if (busState == BUS_DATA) begin
        addrCnt <= addrCnt + 5'd1;
      end
    end
  end

  // Write source: only one port is live, chosen by the mode strap.
  always_comb begin
    wrValid = 1'b0;
    wrItem  = '0;
    if (modeI2c) begin
      wrValid     = busValid;
      wrItem.addr = addrCnt;
      wrItem.data = byteReg;
    end else begin
      wrValid     = clkEn & wireValid;
      wrItem.addr = wireFrame[FRAME_ADDR_LSB +: 5];
      wrItem.data = wireFrame[7:0];
    end
  end

  function automatic logic writable(input logic [4:0] addr);
    return (addr <= ADDR_EMPH) && (addr != ADDR_RSV_A) &&
           (addr != ADDR_RSV_B);
  endfunction : writable

  // Register bank; the timing reset bit never clears it.
  always_ff @(posedge ref_clk) begin
    if (regReset) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regFile[i] <= RESET_VAL[i];
      end
    end else if (wrValid && writable(wrItem.addr)) begin
      regFile[wrItem.addr[3:0]] <= wrItem.data & WRITE_MASK[wrItem.addr[3:0]];
      if (wrItem.addr == ADDR_MAIN) begin
        regFile[ADDR_PWR[3:0]][PWR_PW1_BIT] <= wrItem.data[MAIN_PW1_BIT];
      end
      if (wrItem.addr == ADDR_PWR) begin
        regFile[ADDR_MAIN[3:0]][MAIN_PW1_BIT] <= wrItem.data[PWR_PW1_BIT];
      end
    end
  end

  function automatic dsc_speed_t speedOf(input logic auto, input logic [1:0] sel);
    dsc_speed_t mode;
    mode = SPD_NORMAL;
    if (auto) begin
      mode = SPD_AUTO;
    end else begin
      unique case (sel)
        2'b01:   mode = SPD_DOUBLE;
        2'b10:   mode = SPD_QUAD;
        default: mode = SPD_NORMAL;
      endcase
    end
    return mode;
  endfunction : speedOf

  function automatic dsc_slot_t slotOf(input logic [1:0] sel);
    dsc_slot_t mode;
    unique case (sel)
      2'b01:   mode = SLOT_WIDE;
      2'b11:   mode = SLOT_NARROW;
      default: mode = SLOT_NONE;
    endcase
    return mode;
  endfunction : slotOf

  logic [7:0] mainR;
  logic [7:0] filtR;
  logic [7:0] pwrR;
  logic [2:0] pwrBits;

  assign mainR   = regFile[ADDR_MAIN[3:0]];
  assign filtR   = regFile[ADDR_FILT[3:0]];
  assign pwrR    = regFile[ADDR_PWR[3:0]];
  assign pwrBits = {pwrR[PWR_PW3_BIT], pwrR[PWR_PW2_BIT], pwrR[PWR_PW1_BIT]};

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrlOut <= '0;
    end else if (clkEn) begin
      ctrlOut.timingResetN   <= mainR[MAIN_RST_BIT];
      ctrlOut.pwrUp          <= pwrBits;
      ctrlOut.allPowerDown   <= ~|pwrBits;
      ctrlOut.multislotSel   <= slotOf(mainR[MAIN_SLOT_LSB +: 2]);
      ctrlOut.audioFormatSel <= mainR[MAIN_FMT_LSB +: 3];
      ctrlOut.autoRatioEn    <= mainR[MAIN_AUTO_BIT];
      ctrlOut.speedMode      <= speedOf(mainR[MAIN_AUTO_BIT], filtR[FILT_RATE_LSB +: 2]);
      ctrlOut.slowRollOff    <= filtR[FILT_SLOW_BIT];
      ctrlOut.emphCurveSel   <= filtR[FILT_CURV_LSB +: 2];
      ctrlOut.gentleMute     <= filtR[FILT_MUTE_BIT];
      for (int c = 0; c < 6; c++) begin
        ctrlOut.gainLevel[8*(5-c) +: 8] <= regFile[ADDR_GAIN0[3:0] + 4'(c)];
      end
      for (int d = 0; d < 3; d++) begin
        ctrlOut.leftPhaseFlip[2-d]  <= regFile[ADDR_FLIP[3:0]][7-2*d];
        ctrlOut.rightPhaseFlip[2-d] <= regFile[ADDR_FLIP[3:0]][6-2*d];
      end
      ctrlOut.emphEnPerDac   <= regFile[ADDR_EMPH[3:0]][EMPH_LSB +: 3];
    end
  end

  dsc_zero_flag u_zero_flag (
    .ref_clk          (ref_clk),
    .reset            (reset),
    .clkEn            (clkEn),
    .chanZero         (chanZero),
    .maskA            (regFile[ADDR_MASK_A[3:0]][CHAN_LSB +: 6]),
    .maskB            (regFile[ADDR_MASK_B[3:0]][CHAN_LSB +: 6]),
    .zeroFlagPolarity (pwrR[PWR_POL_BIT]),
    .timingResetN     (mainR[MAIN_RST_BIT]),
    .allPowerDown     (~|pwrBits),
    .zeroFlagOutA     (zeroFlagOutA),
    .zeroFlagOutB     (zeroFlagOutB)
  );

endmodule : dsc_serial_ctrl
`default_nettype wire

// ---- hdl/dsc_wire_shift.sv ----
`timescale 1ns/1ns
`default_nettype none

module dsc_wire_shift
  import dsc_pkg::*;
(
  // Link clock and pins
  input  wire logic                  ctrlSerialClock,
  input  wire logic                  portSelectN,
  input  wire logic                  ctrlSerialIn,
  // Last sixteen bits shifted in
  output logic [FRAME_BITS-1:0]      frameBits
);

  // The clock stops while select is high, so the word is stable at commit.
  always_ff @(posedge ctrlSerialClock) begin
    if (!portSelectN) begin
      frameBits <= {frameBits[FRAME_BITS-2:0], ctrlSerialIn};
    end
  end

endmodule : dsc_wire_shift
`default_nettype wire

// ---- hdl/dsc_zero_flag.sv ----
`timescale 1ns/1ns
`default_nettype none

module dsc_zero_flag
  import dsc_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       clkEn,
  // Controls
  input  wire logic [5:0] chanZero,
  input  wire logic [5:0] maskA,
  input  wire logic [5:0] maskB,
  input  wire logic       zeroFlagPolarity,
  input  wire logic       timingResetN,
  input  wire logic       allPowerDown,
  // Flags
  output logic            zeroFlagOutA,
  output logic            zeroFlagOutB
);

  // An empty mask disables detection for that flag.
  function automatic logic detect(input logic [5:0] zero, input logic [5:0] mask);
    return (|mask) & (&(zero | ~mask));
  endfunction : detect

  function automatic logic drive(input logic hit);
    logic level;
    level = hit ^ zeroFlagPolarity;
    if (!timingResetN) begin
      level = 1'b1;
    end
    if (allPowerDown) begin
      level = 1'b0;
    end
    return level;
  endfunction : drive

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      zeroFlagOutA <= 1'b0;
      zeroFlagOutB <= 1'b0;
    end else if (clkEn) begin
      zeroFlagOutA <= drive(detect(chanZero, maskA));
      zeroFlagOutB <= drive(detect(chanZero, maskB));
    end
  end

endmodule : dsc_zero_flag
`default_nettype wire

// ---- pkg/dsc_pkg.sv ----
package dsc_pkg;

  localparam int unsigned REG_COUNT = 15;

  localparam logic [4:0] ADDR_MAIN   = 5'h00;
  localparam logic [4:0] ADDR_FILT   = 5'h01;
  localparam logic [4:0] ADDR_PWR    = 5'h02;
  localparam logic [4:0] ADDR_GAIN0  = 5'h03;
  localparam logic [4:0] ADDR_RSV_A  = 5'h09;
  localparam logic [4:0] ADDR_RSV_B  = 5'h0a;
  localparam logic [4:0] ADDR_FLIP   = 5'h0b;
  localparam logic [4:0] ADDR_MASK_A = 5'h0c;
  localparam logic [4:0] ADDR_MASK_B = 5'h0d;
  localparam logic [4:0] ADDR_EMPH   = 5'h0e;

  localparam int unsigned MAIN_RST_BIT  = 0;
  localparam int unsigned MAIN_PW1_BIT  = 1;
  localparam int unsigned MAIN_FMT_LSB  = 2;
  localparam int unsigned MAIN_SLOT_LSB = 5;
  localparam int unsigned MAIN_AUTO_BIT = 7;
  localparam int unsigned FILT_MUTE_BIT = 0;
  localparam int unsigned FILT_CURV_LSB = 1;
  localparam int unsigned FILT_RATE_LSB = 3;
  localparam int unsigned FILT_SLOW_BIT = 5;
  localparam int unsigned PWR_PW1_BIT   = 1;
  localparam int unsigned PWR_POL_BIT   = 2;
  localparam int unsigned PWR_PW2_BIT   = 5;
  localparam int unsigned PWR_PW3_BIT   = 6;
  localparam int unsigned CHAN_LSB      = 2;
  localparam int unsigned EMPH_LSB      = 1;

  localparam logic [7:0] RESET_VAL [REG_COUNT] = '{
    8'h0b, 8'h02, 8'h62, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] WRITE_MASK [REG_COUNT] = '{
    8'hff, 8'h3f, 8'h66, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'h00, 8'h00, 8'hfc, 8'hfc, 8'hfc, 8'h0e};

  localparam int unsigned FRAME_BITS    = 16;
  localparam int unsigned FRAME_CHIP_HI = 15;
  localparam int unsigned FRAME_CHIP_LO = 14;
  localparam int unsigned FRAME_RW      = 13;
  localparam int unsigned FRAME_ADDR_LSB = 8;
  localparam logic       CHIP_LOW_FIXED = 1'b1;
  localparam logic       WIRE_WRITE     = 1'b1;
  localparam logic [4:0] BUS_ADDR_FIXED = 5'b00100;
  localparam logic [3:0] BYTE_BITS      = 4'd8;

  localparam int unsigned SYNC_W    = 7;
  localparam int unsigned SYNC_HWR  = 0;
  localparam int unsigned SYNC_CSN  = 1;
  localparam int unsigned SYNC_MODE = 2;
  localparam int unsigned SYNC_SCL  = 3;
  localparam int unsigned SYNC_SDA  = 4;
  localparam int unsigned SYNC_DEV_ADDR_BIT1 = 5;
  localparam int unsigned SYNC_DEV_ADDR_BIT0 = 6;
  localparam logic [6:0]  SYNC_IDLE = 7'h1a;

  typedef enum logic [1:0] {SPD_NORMAL, SPD_DOUBLE, SPD_QUAD, SPD_AUTO} dsc_speed_t;
  typedef enum logic [1:0] {SLOT_NONE, SLOT_WIDE, SLOT_NARROW} dsc_slot_t;

  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] data;
  } dsc_write_t;

  typedef struct packed {
    logic       timingResetN;
    logic [2:0] pwrUp;
    logic       allPowerDown;
    dsc_slot_t  multislotSel;
    logic [2:0] audioFormatSel;
    logic       autoRatioEn;
    dsc_speed_t speedMode;
    logic       slowRollOff;
    logic [1:0] emphCurveSel;
    logic       gentleMute;
    logic [47:0] gainLevel;
    logic [2:0] leftPhaseFlip;
    logic [2:0] rightPhaseFlip;
    logic [2:0] emphEnPerDac;
  } dsc_ctrl_t;

endpackage : dsc_pkg

// ---- verification/dsc_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none

module dsc_host_model (
  // Pins driven by the host
  output logic     linkClk,
  output logic     selN,
  output logic     hostData,
  // Wire level seen by the host
  input wire logic sdaWire
);
  logic acked;

  initial begin
    linkClk = 1'b1;
    selN = 1'b1;
    hostData = 1'b1;
    acked = 1'b0;
  end

  task automatic wireFrame(input logic [15:0] f);
    #3 selN = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      #80 linkClk = 1'b0;
      hostData = f[i];
      #80 linkClk = 1'b1;
    end
    #80 selN = 1'b1;
    hostData = 1'b1;
    #40;
  endtask : wireFrame

  task automatic busStart();
    #3 hostData = 1'b0;
    #80 linkClk = 1'b0;
  endtask : busStart

  task automatic busByte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      #40 hostData = b[i];
      #40 linkClk = 1'b1;
      #80 linkClk = 1'b0;
    end
    #40 hostData = 1'b1;
    #40 linkClk = 1'b1;
    #40 acked = !sdaWire;
    #40 linkClk = 1'b0;
  endtask : busByte

  task automatic busStop();
    #40 hostData = 1'b0;
    #40 linkClk = 1'b1;
    #80 hostData = 1'b1;
    #80;
  endtask : busStop
endmodule : dsc_host_model

`default_nettype wire

// ---- verification/dsc_serial_ctrl_sva.sv ----
`timescale 1ns/1ns
`default_nettype none

module dsc_serial_ctrl_sva
  import dsc_pkg::*;
(
  // Clock and reset
  input wire logic      ref_clk,
  input wire logic      reset,
  // Pins
  input wire logic      hwResetN,
  input wire logic      busModeI2c,
  input wire logic      portSelectN,
  input wire logic      i2cClockIn,
  input wire logic      sdaOut,
  input wire logic      sdaDriveN,
  input wire logic      zeroFlagOutA,
  input wire logic      zeroFlagOutB,
  // Decoded controls
  input wire dsc_ctrl_t ctrlOut
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  sequence ackStart;
    $fell(sdaDriveN);
  endsequence
  sequence selHeld;
    (!busModeI2c && !portSelectN) [*6];
  endsequence

  sda_level_a: assert property (sdaOut == 1'b0)
    else $error("sda data level not low");
  sda_mode_a: assert property (!busModeI2c [*4] |-> sdaDriveN)
    else $error("sda driven in three-wire mode");
  reset_clear_a: assert property (disable iff (1'b0) reset |=> ctrlOut == '0 && sdaDriveN
    && !zeroFlagOutA && !zeroFlagOutB) else $error("outputs not cleared by reset");
  timing_flag_a: assert property ($fell(ctrlOut.timingResetN) && !ctrlOut.allPowerDown
    |-> ##[0:3] (zeroFlagOutA && zeroFlagOutB)) else $error("flags not high in timing reset");
  power_flag_a: assert property ($rose(ctrlOut.allPowerDown)
    |-> ##[0:3] (!zeroFlagOutA && !zeroFlagOutB)) else $error("flags not low when powered down");
  speed_auto_a: assert property (ctrlOut.autoRatioEn |-> ctrlOut.speedMode == SPD_AUTO)
    else $error("auto ratio does not override rate");
  ack_hold_a: assert property (ackStart |-> !sdaDriveN [*8])
    else $error("acknowledge too short");
  ack_window_a: assert property (ackStart |-> !i2cClockIn)
    else $error("acknowledge started with clock high");
  frame_wait_a: assert property (selHeld |-> $stable(ctrlOut))
    else $error("controls changed while select low");
  hw_default_a: assert property (!hwResetN [*6] |-> ctrlOut.gainLevel == {6{8'hff}}
    && ctrlOut.audioFormatSel == 3'b010 && ctrlOut.timingResetN && !ctrlOut.gentleMute)
    else $error("defaults not loaded by reset pin");
endmodule : dsc_serial_ctrl_sva

bind dsc_serial_ctrl dsc_serial_ctrl_sva u_sva (
  .ref_clk(ref_clk), .reset(reset), .hwResetN(hwResetN), .busModeI2c(busModeI2c),
  .portSelectN(portSelectN), .i2cClockIn(i2cClockIn), .sdaOut(sdaOut),
  .sdaDriveN(sdaDriveN), .zeroFlagOutA(zeroFlagOutA), .zeroFlagOutB(zeroFlagOutB),
  .ctrlOut(ctrlOut));

`default_nettype wire

// ---- verification/dsc_serial_ctrl_tb.sv ----
`timescale 1ns/1ns
`default_nettype none

module dsc_serial_ctrl_tb
  import dsc_pkg::*;
;
  typedef struct packed {
    logic [3:0]  sel;
    logic [47:0] val;
  } dsc_note_t;

  logic       ref_clk, reset, clkEn, hwResetN, busModeI2c, devAddrBit1, devAddrBit0;
  logic       linkClk, selN, hostData, sdaWire, sdaOut, sdaDriveN;
  logic       zeroFlagOutA, zeroFlagOutB, flagA, flagB;
  logic [5:0] chanZero;
  logic [7:0] gainVal, maskVal;
  dsc_ctrl_t  ctrlOut;
  dsc_note_t  notes[$];
  int         miscompares, samples_checked;
  event       chk;

  assign sdaWire = hostData & (sdaDriveN | sdaOut);

  dsc_serial_ctrl u_dut (
    .ref_clk(ref_clk), .reset(reset), .clkEn(clkEn), .hwResetN(hwResetN),
    .busModeI2c(busModeI2c), .devAddrBit1(devAddrBit1), .devAddrBit0(devAddrBit0),
    .ctrlSerialClock(linkClk), .portSelectN(selN), .ctrlSerialIn(sdaWire),
    .i2cClockIn(linkClk), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaDriveN(sdaDriveN),
    .chanZero(chanZero), .zeroFlagOutA(zeroFlagOutA), .zeroFlagOutB(zeroFlagOutB),
    .ctrlOut(ctrlOut));

  dsc_host_model u_host (.linkClk(linkClk), .selN(selN), .hostData(hostData), .sdaWire(sdaWire));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  function automatic logic [47:0] pick(input int s);
    case (s)
      0:       pick = 48'(ctrlOut.timingResetN);
      1:       pick = 48'(ctrlOut.gentleMute);
      2:       pick = 48'(ctrlOut.speedMode);
      3:       pick = 48'(ctrlOut.multislotSel);
      4:       pick = ctrlOut.gainLevel;
      5:       pick = 48'(ctrlOut.allPowerDown);
      6:       pick = 48'({zeroFlagOutA, zeroFlagOutB});
      7:       pick = 48'(ctrlOut.audioFormatSel);
      default: pick = 48'(ctrlOut.emphEnPerDac);
    endcase
  endfunction : pick

  task automatic cmpCtrl(input logic [47:0] exp, input logic [47:0] act);
    samples_checked++;
    if (act !== exp) begin
      miscompares++;
      $display("[FAIL] %0t control got %h expected %h", $time, act, exp);
    end
  endtask : cmpCtrl

  task automatic cmpAck(input logic exp, input logic act);
    samples_checked++;
    if (act !== exp) begin
      miscompares++;
      $display("[FAIL] %0t acknowledge got %b expected %b", $time, act, exp);
    end
  endtask : cmpAck

  initial begin : monitor
    dsc_note_t n;
    forever begin
      @(chk);
      while (notes.size() > 0) begin
        n = notes.pop_front();
        if (n.sel == 4'h8)
          cmpAck(n.val[0], u_host.acked);
        else
          cmpCtrl(n.val, pick(int'(n.sel)));
      end
    end
  end

  task automatic note(input int s, input logic [47:0] v);
    notes.push_back({4'(s), v});
  endtask : note

  task automatic settle();
    repeat (16) @(negedge ref_clk);
    -> chk;
    repeat (2) @(negedge ref_clk);
  endtask : settle

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    u_host.wireFrame({devAddrBit1, CHIP_LOW_FIXED, WIRE_WRITE, a, d});
  endtask : wr

  task automatic busAck(input logic [7:0] b, input logic exp);
    u_host.busByte(b);
    note(8, 48'(exp));
    -> chk;
    @(negedge ref_clk);
  endtask : busAck

  task automatic iw(input logic [4:0] a, input logic [7:0] d[$]);
    u_host.busStart();
    busAck({BUS_ADDR_FIXED, devAddrBit1, devAddrBit0, 1'b0}, 1'b1);
    busAck({3'b000, a}, 1'b1);
    foreach (d[i]) busAck(d[i], 1'b1);
    u_host.busStop();
  endtask : iw

  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  initial begin
    #300000;
    miscompares++;
    summarize();
  end

  initial begin : main
    void'($urandom(76));
    reset = 1'b1;
    hwResetN = 1'b0;
    busModeI2c = 1'b0;
    clkEn = 1'b1;
    chanZero = 6'h00;
    devAddrBit1 = 1'($urandom);
    devAddrBit0 = 1'b0;
    repeat (10) @(negedge ref_clk);
    reset = 1'b0;
    repeat (4) @(negedge ref_clk);
    hwResetN = 1'b1;
    repeat (8) @(negedge ref_clk);
    note(0, 48'h1);
    note(4, {6{8'hff}});
    note(7, 48'h2);
    note(3, 48'(SLOT_NONE));
    settle();
    wr(ADDR_FILT, 8'h01);
    note(1, 48'h1);
    settle();
    u_host.wireFrame({~devAddrBit1, 2'b11, ADDR_FILT, 8'h00});
    u_host.wireFrame({devAddrBit1, 2'b10, ADDR_FILT, 8'h00});
    note(1, 48'h1);
    settle();
    for (int r = 0; r < 3; r++) begin
      wr(ADDR_FILT, 8'(8'h01 | (r << 3)));
      note(2, 48'(r));
      settle();
    end
    wr(ADDR_MAIN, 8'h8b);
    note(2, 48'(SPD_AUTO));
    settle();
    for (int s = 0; s < 3; s++) begin
      wr(ADDR_MAIN, {1'b0, (s == 2) ? 2'b11 : 2'(s), 5'h0b});
      note(3, 48'(s));
      settle();
    end
    wr(ADDR_MAIN, 8'h0a);
    note(0, 48'h0);
    note(6, 48'h3);
    note(1, 48'h1);
    settle();
    busModeI2c = 1'b1;
    devAddrBit0 = 1'($urandom);
    hwResetN = 1'b0;
    repeat (8) @(negedge ref_clk);
    hwResetN = 1'b1;
    repeat (8) @(negedge ref_clk);
    note(1, 48'h0);
    settle();
    u_host.busStart();
    busAck({BUS_ADDR_FIXED, ~devAddrBit1, devAddrBit0, 1'b0}, 1'b0);
    u_host.busStop();
    u_host.busStart();
    busAck({BUS_ADDR_FIXED, devAddrBit1, devAddrBit0, 1'b1}, 1'b0);
    u_host.busStop();
    gainVal = 8'($urandom);
    iw(ADDR_GAIN0, '{gainVal, gainVal, gainVal, gainVal, gainVal, gainVal});
    note(4, {6{gainVal}});
    settle();
    iw(5'h1f, '{8'h5a, 8'h0a, 8'h01});
    note(0, 48'h0);
    note(1, 48'h1);
    settle();
    maskVal = {6'($urandom) | 6'h01, 2'b00};
    iw(ADDR_MAIN, '{8'h0b});
    iw(ADDR_MASK_A, '{maskVal, 8'hfc});
    iw(ADDR_EMPH, '{8'h0e});
    note(9, 48'h7);
    for (int i = 0; i < 4; i++) begin
      if (i == 2) begin
        iw(ADDR_PWR, '{8'h66});
        @(negedge ref_clk);
      end
      chanZero = i[0] ? 6'h3f : 6'($urandom);
      flagA = &(chanZero | ~maskVal[7:2]);
      flagB = &chanZero;
      note(6, 48'({flagA, flagB} ^ {2{i >= 2}}));
      settle();
    end
    iw(ADDR_PWR, '{8'h04});
    note(5, 48'h1);
    note(6, 48'h0);
    settle();
    iw(ADDR_MAIN, '{8'h0b});
    note(5, 48'h0);
    settle();
    summarize();
  end
endmodule : dsc_serial_ctrl_tb

`default_nettype wire
